// >>> rhbm_cfg.svh
// constants for the resonant half-bridge mode controller
// assumes a 250 MHz system clock; analog results arrive as digital levels
`ifndef RHBM_CFG_SVH
`define RHBM_CFG_SVH

`define RHBM_CLK_MHZ         250
// timing in ns, cycles derived with minimum rounded up and maximum rounded down
`define RHBM_TON_MIN_NS      400
`define RHBM_TON_MAX_NS      20000
`define RHBM_TNO_MIN_NS      100
`define RHBM_TNO_MAX_NS      1000
`define RHBM_TON_MIN_CYC     ((`RHBM_TON_MIN_NS * `RHBM_CLK_MHZ + 999) / 1000)
`define RHBM_TON_MAX_CYC     ((`RHBM_TON_MAX_NS * `RHBM_CLK_MHZ) / 1000)
`define RHBM_TNO_MIN_CYC     ((`RHBM_TNO_MIN_NS * `RHBM_CLK_MHZ + 999) / 1000)
`define RHBM_TNO_MAX_CYC     ((`RHBM_TNO_MAX_NS * `RHBM_CLK_MHZ) / 1000)
// minimum low-power cycle rate in Hz, longest cycle in clock cycles
`define RHBM_LP_MIN_HZ       23000
`define RHBM_LP_MAX_CYC      ((`RHBM_CLK_MHZ * 1000000) / `RHBM_LP_MIN_HZ)
// burst target rates in Hz
`define RHBM_BURST_HZ_0      200
`define RHBM_BURST_HZ_1      400
`define RHBM_BURST_HZ_2      800
`define RHBM_BURST_HZ_3      1600
// optocurrent levels in microamps, sense resistor in ohms
`define RHBM_OPTO_BURST_UA   106
`define RHBM_OPTO_TARGET_UA  85
`define RHBM_SENSE_OHM       12000
`define RHBM_TARGET_MV       ((`RHBM_OPTO_TARGET_UA * `RHBM_SENSE_OHM) / 1000)
// gap limits and steps, in gap code units; then offset divider and hold step in clocks, burst count reset
`define RHBM_GAP_MIN         10'h040
`define RHBM_GAP_MAX         10'h3FF
`define RHBM_GAP_LP_BOOST    10'h080
`define RHBM_GAP_TRANS_STEP  10'h040
`define RHBM_OFS_DIV         16'h0FA0
`define RHBM_HOLD_STEP       16'h0010
`define RHBM_BURST_CNT_RST   8'h04

`endif

// >>> rhbm_pkg.sv
// types for the resonant half-bridge mode controller
// used only by the controller module
package rhbm_pkg;
    typedef enum logic [5:0] {
        RHBM_LS    = 6'h01,
        RHBM_DT_LH = 6'h02,
        RHBM_HS    = 6'h04,
        RHBM_DT_HL = 6'h08,
        RHBM_HOLD  = 6'h10,
        RHBM_IDLE  = 6'h20
    } rhbm_state_t;

    typedef enum logic [2:0] {
        RHBM_MODE_HP    = 3'h1,
        RHBM_MODE_LP    = 3'h2,
        RHBM_MODE_BURST = 3'h4
    } rhbm_mode_t;
endpackage

// >>> rhbm_ctrl.sv
// operating-mode controller for a resonant half-bridge converter
// expects comparator levels and a digitised optocurrent; drives gate commands
`include "rhbm_cfg.svh"
`timescale 1ns/1ps
module rhbm_ctrl #(
    parameter int unsigned GAP_W = 10,
    parameter int unsigned TON_MAX_CYC = `RHBM_TON_MAX_CYC,
    parameter int unsigned LP_MAX_CYC  = `RHBM_LP_MAX_CYC,
    parameter int unsigned CLK_HZ      = `RHBM_CLK_MHZ * 1000000
) (
    input  wire logic              clk_sys_i,          // 250 MHz clock
    input  wire logic              rst_b_i,            // async reset, active low
    input  wire logic              cap_above_high_i,   // cap sense above high threshold
    input  wire logic              cap_below_low_i,    // cap sense below low threshold
    input  wire logic              hb_peak_i,          // half-bridge node peak seen
    input  wire logic              cur_pos_i,          // resonant current above zero
    input  wire logic              cur_neg_i,          // resonant current below zero
    input  wire logic              overcurrent_i,      // current beyond overcurrent limit
    input  wire logic              near_cap_i,         // close to capacitive mode
    input  wire logic [9:0]        opto_ua_i,          // feedback optocurrent, microamps
    input  wire logic [GAP_W-1:0]  lp_transition_i,    // low-power transition level
    input  wire logic [1:0]        burst_sel_i,        // burst rate select
    output logic                   low_side_gate_o,    // low-side gate command
    output logic                   high_side_gate_o,   // high-side gate command
    output logic [GAP_W-1:0]       cap_gap_o,          // threshold gap to the comparators
    output logic [2:0]             mode_o              // one-hot operating mode
);

    localparam int unsigned TON_MIN = `RHBM_TON_MIN_CYC;
    localparam int unsigned TNO_MIN = `RHBM_TNO_MIN_CYC;
    localparam int unsigned TNO_MAX = `RHBM_TNO_MAX_CYC;

    // limit a value between bounds
    function automatic logic [GAP_W-1:0] clampg(input int v);
        if (v < int'(`RHBM_GAP_MIN))
            return GAP_W'(`RHBM_GAP_MIN);
        if (v > int'(`RHBM_GAP_MAX))
            return GAP_W'(`RHBM_GAP_MAX);
        return GAP_W'(v);
    endfunction

    // burst target period in clock cycles
    function automatic logic [31:0] burst_period(input logic [1:0] sel);
        case (sel)
            2'h0: return 32'(CLK_HZ / `RHBM_BURST_HZ_0);
            2'h1: return 32'(CLK_HZ / `RHBM_BURST_HZ_1);
            2'h2: return 32'(CLK_HZ / `RHBM_BURST_HZ_2);
            default: return 32'(CLK_HZ / `RHBM_BURST_HZ_3);
        endcase
    endfunction

    // reset release through two flops
    logic rst_m, rst_s;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // two-stage comparator sync
    // keeps a comparator edge from splitting across two state decisions
    logic [6:0] sync_a, sync_b;
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {cap_above_high_i, cap_below_low_i, hb_peak_i, cur_pos_i,
                       cur_neg_i, overcurrent_i, near_cap_i};
            sync_b <= sync_a;
        end
    end
    logic s_high, s_low, s_peak, s_pos, s_neg, s_oc, s_ncap;
    assign {s_high, s_low, s_peak, s_pos, s_neg, s_oc, s_ncap} = sync_b;

    // optocurrent as power demand, filtered one stage
    logic [9:0] opto;
    logic [9:0] opto_prev;
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            opto      <= 10'h000;
            opto_prev <= 10'h000;
        end else begin
            opto      <= opto_ua_i;
            opto_prev <= opto;
        end
    end
    // transients: load rise lowers optocurrent
    logic pos_trans, neg_trans;
    assign pos_trans = (opto < opto_prev) && (opto < 10'(`RHBM_OPTO_TARGET_UA));
    assign neg_trans = (opto > opto_prev) && (opto > 10'(`RHBM_OPTO_TARGET_UA));

    logic [15:0] ofs_div;
    logic [GAP_W-1:0] offset;
    logic opto_mv_low;
    assign opto_mv_low = (32'(opto) * 32'(`RHBM_SENSE_OHM) / 32'h3E8) < 32'(`RHBM_TARGET_MV);
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            ofs_div <= 16'h0000;
            offset  <= '0;
        end else if (ofs_div == 16'(`RHBM_OFS_DIV)) begin
            ofs_div <= 16'h0000;
            if (opto_mv_low && offset != '1)
                offset <= offset + 1'b1;
            else if (!opto_mv_low && opto > 10'(`RHBM_OPTO_TARGET_UA) && offset != '0)
                offset <= offset - 1'b1;
        end else begin
            ofs_div <= ofs_div + 16'h0001;
        end
    end

    // demand: lower optocurrent means more power, plus offset
    logic [GAP_W-1:0] demand;
    assign demand = clampg(int'(GAP_W'(`RHBM_GAP_MAX)) - 2 * int'(opto) + int'(offset));

    // mode and gap regulation
    rhbm_pkg::rhbm_mode_t mode;
    logic [GAP_W-1:0]     gap;
    logic [15:0]          hold_len;
    logic                 cyc_end;       // one low-power cycle finished
    logic [31:0]          lp_cyc_cnt;    // clocks since low-power cycle start
    logic [31:0]          last_cyc_len;  // length of the last finished low-power cycle
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            mode     <= rhbm_pkg::RHBM_MODE_HP;
            gap      <= GAP_W'(`RHBM_GAP_MAX);
            hold_len <= 16'h0000;
        end else begin
            case (mode)
                rhbm_pkg::RHBM_MODE_HP: begin
                    gap <= demand;
                    if (demand < lp_transition_i) begin
                        mode     <= rhbm_pkg::RHBM_MODE_LP;
                        gap      <= clampg(int'(demand) + int'(`RHBM_GAP_LP_BOOST));
                        hold_len <= 16'h0000;
                    end
                end
                rhbm_pkg::RHBM_MODE_LP: begin
                    if (pos_trans) begin
                        gap      <= clampg(int'(gap) + int'(`RHBM_GAP_TRANS_STEP));
                        hold_len <= 16'h0000;
                    end else if (demand >= lp_transition_i + GAP_W'(`RHBM_GAP_LP_BOOST)) begin
                        mode <= rhbm_pkg::RHBM_MODE_HP;
                    end else if (cyc_end) begin
                        if (gap > GAP_W'(`RHBM_GAP_MIN)) begin
                            // shrink gap, fixed duty
                            // gap falls twice as fast as demand so it can reach the minimum;
                            // demand plus boost alone would stop well above it
                            gap <= clampg(2 * int'(demand) + int'(`RHBM_GAP_LP_BOOST) - int'(lp_transition_i));
                        end else if (opto > 10'(`RHBM_OPTO_TARGET_UA)) begin
                            // stop at 23 kHz period
                            // the running counter restarts at cyc_end, so use the finished length
                            if (last_cyc_len + 32'(`RHBM_HOLD_STEP) < 32'(LP_MAX_CYC))
                                hold_len <= hold_len + 16'(`RHBM_HOLD_STEP);
                            else if (opto > 10'(`RHBM_OPTO_BURST_UA))
                                mode <= rhbm_pkg::RHBM_MODE_BURST;
                        end else if (opto < 10'(`RHBM_OPTO_TARGET_UA) && hold_len != 16'h0000) begin
                            hold_len <= hold_len - 16'(`RHBM_HOLD_STEP);
                        end
                    end
                end
                rhbm_pkg::RHBM_MODE_BURST: begin
                    gap <= GAP_W'(`RHBM_GAP_MIN);
                    if (opto < 10'(`RHBM_OPTO_TARGET_UA) && pos_trans) begin
                        mode     <= rhbm_pkg::RHBM_MODE_LP;
                        gap      <= clampg(int'(`RHBM_GAP_MIN) + int'(`RHBM_GAP_TRANS_STEP));
                        hold_len <= 16'h0000;
                    end
                end
                default: mode <= rhbm_pkg::RHBM_MODE_HP;
            endcase
        end
    end

    // burst scheduling: on-phase counts cycles, off-phase holds
    logic [31:0] burst_timer;
    logic [7:0]  burst_cycles;
    logic [7:0]  burst_done;
    logic        burst_on;
    logic        burst_start;
    assign burst_start = (mode == rhbm_pkg::RHBM_MODE_BURST) && !burst_on &&
                         ((opto < 10'(`RHBM_OPTO_BURST_UA)) || pos_trans);
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            burst_timer  <= 32'h0000_0000;
            burst_cycles <= 8'(`RHBM_BURST_CNT_RST);
            burst_done   <= 8'h00;
            burst_on     <= 1'b0;
        end else if (mode != rhbm_pkg::RHBM_MODE_BURST) begin
            burst_timer <= 32'h0000_0000;
            burst_done  <= 8'h00;
            burst_on    <= 1'b0;
        end else if (burst_start) begin
            burst_timer <= 32'h0000_0000;
            burst_done  <= 8'h00;
            burst_on    <= 1'b1;
            if (burst_timer < burst_period(burst_sel_i) && burst_cycles != 8'hFF)
                burst_cycles <= burst_cycles + 8'h01;
        end else begin
            if (burst_timer != 32'hFFFF_FFFF)
                burst_timer <= burst_timer + 32'h0000_0001;
            if (burst_on && cyc_end) begin
                burst_done <= burst_done + 8'h01;
                if (burst_done + 8'h01 >= burst_cycles)
                    burst_on <= 1'b0;
            end
        end
    end

    // half-bridge sequencing
    rhbm_pkg::rhbm_state_t st;
    logic [31:0] tcnt;
    logic [1:0]  half_cnt;     // half-cycles done in low-power cycle
    logic        lp_like;
    assign lp_like = (mode != rhbm_pkg::RHBM_MODE_HP);
    // in burst mode, outside a burst-on the sequencer parks in the idle state
    logic run_ok;
    assign run_ok = (mode != rhbm_pkg::RHBM_MODE_BURST) || burst_on || burst_start;

    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            st         <= rhbm_pkg::RHBM_LS;
            tcnt       <= 32'h0000_0000;
            half_cnt   <= 2'h0;
            lp_cyc_cnt <= 32'h0000_0000;
            last_cyc_len <= 32'h0000_0000;
            cyc_end    <= 1'b0;
        end else begin
            cyc_end    <= 1'b0;
            tcnt       <= tcnt + 32'h0000_0001;
            // cycle time only matters in low-power operation; held at zero in high power
            lp_cyc_cnt <= lp_like ? lp_cyc_cnt + 32'h0000_0001 : 32'h0000_0000;
            case (st)
                // low side for at least minimum on-time
                rhbm_pkg::RHBM_LS: begin
                    if (tcnt >= 32'(TON_MIN) &&
                        (s_low || s_oc || s_ncap || tcnt >= 32'(TON_MAX_CYC))) begin
                        st   <= rhbm_pkg::RHBM_DT_LH;
                        tcnt <= 32'h0000_0000;
                        if (lp_like && half_cnt == 2'h2) begin
                            st   <= rhbm_pkg::RHBM_HOLD;
                            half_cnt <= 2'h0;
                        end else begin
                            // high power keeps the count in step so a low-power entry ends on a low side
                            half_cnt <= lp_like ? half_cnt + 2'h1 : 2'h1;
                        end
                    end
                end
                rhbm_pkg::RHBM_DT_LH: begin
                    if (tcnt >= 32'(TNO_MIN) && !s_pos && (s_peak || tcnt >= 32'(TNO_MAX))) begin
                        st   <= rhbm_pkg::RHBM_HS;
                        tcnt <= 32'h0000_0000;
                    end
                end
                rhbm_pkg::RHBM_HS: begin
                    if (tcnt >= 32'(TON_MIN) &&
                        (s_high || s_oc || s_ncap || tcnt >= 32'(TON_MAX_CYC))) begin
                        st       <= rhbm_pkg::RHBM_DT_HL;
                        tcnt     <= 32'h0000_0000;
                        half_cnt <= lp_like ? half_cnt + 2'h1 : 2'h2;
                    end
                end
                // mirrored dead time, current sign inverted
                rhbm_pkg::RHBM_DT_HL: begin
                    if (tcnt >= 32'(TNO_MIN) && !s_neg && (s_peak || tcnt >= 32'(TNO_MAX))) begin
                        st   <= rhbm_pkg::RHBM_LS;
                        tcnt <= 32'h0000_0000;
                    end
                end
                // hold: both gates off until the cycle period elapses
                rhbm_pkg::RHBM_HOLD: begin
                    // half the active time gives 67 % duty; lp_cyc_cnt runs on here, so take tcnt off
                    if (tcnt >= ((lp_cyc_cnt - tcnt) >> 1) + 32'(hold_len)
                        || (pos_trans && mode == rhbm_pkg::RHBM_MODE_LP)
                        || mode == rhbm_pkg::RHBM_MODE_HP) begin
                        cyc_end <= 1'b1;
                        last_cyc_len <= lp_cyc_cnt;
                        st      <= run_ok ? rhbm_pkg::RHBM_LS : rhbm_pkg::RHBM_IDLE;
                        tcnt    <= 32'h0000_0000;
                        lp_cyc_cnt <= 32'h0000_0000;
                    end
                end
                rhbm_pkg::RHBM_IDLE: begin
                    if (run_ok) begin
                        st         <= rhbm_pkg::RHBM_LS;
                        tcnt       <= 32'h0000_0000;
                        lp_cyc_cnt <= 32'h0000_0000;
                    end
                end
                default: st <= rhbm_pkg::RHBM_LS;
            endcase
        end
    end

    // gate outputs registered, exclusive by state
    // gates lag the state by one clock; dead-time and hold states drive both low
    always_ff @(posedge clk_sys_i or negedge rst_s) begin
        if (!rst_s) begin
            low_side_gate_o  <= 1'b0;
            high_side_gate_o <= 1'b0;
            cap_gap_o        <= GAP_W'(`RHBM_GAP_MAX);
            mode_o           <= 3'h1;
        end else begin
            low_side_gate_o  <= (st == rhbm_pkg::RHBM_LS);
            high_side_gate_o <= (st == rhbm_pkg::RHBM_HS);
            cap_gap_o        <= gap;
            mode_o           <= mode;
        end
    end

endmodule

// >>> rhbm_ctrl_sva.sv
// assertions on the gate commands and threshold gap of the half-bridge mode controller
// sees only the controller's ports; bound to every controller instance below
`timescale 1ns/1ps
module rhbm_ctrl_chk #(
    parameter int unsigned GAP_W       = 10,
    parameter int unsigned TON_MAX_CYC = 5000
) (
    input wire logic             clk_sys_i,        // system clock
    input wire logic             rst_b_i,          // async reset, active low
    input wire logic             cap_above_high_i, // cap above high threshold
    input wire logic             cap_below_low_i,  // cap below low threshold
    input wire logic             hb_peak_i,        // node peak seen
    input wire logic             cur_pos_i,        // current above zero
    input wire logic             cur_neg_i,        // current below zero
    input wire logic             overcurrent_i,    // overcurrent flag
    input wire logic             near_cap_i,       // near capacitive flag
    input wire logic [9:0]       opto_ua_i,        // optocurrent
    input wire logic [GAP_W-1:0] lp_transition_i,  // transition level
    input wire logic [1:0]       burst_sel_i,      // burst rate select
    input wire logic             low_side_gate_o,  // low gate command
    input wire logic             high_side_gate_o, // high gate command
    input wire logic [GAP_W-1:0] cap_gap_o,        // threshold gap
    input wire logic [2:0]       mode_o            // one-hot mode
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic [15:0] on_cnt;
    logic [15:0] dead_cnt;
    logic        seen_on;
    logic        last_hs;
    // cycles the active gate has been on
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            on_cnt <= 16'h0000;
        end else begin
            on_cnt <= (low_side_gate_o || high_side_gate_o) ? on_cnt + 16'h0001 : 16'h0000;
        end
    end
    // cycles both gates have been off; seen_on skips the first turn-on
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dead_cnt <= 16'h0000;
            seen_on  <= 1'b0;
            last_hs  <= 1'b0;
        end else begin
            dead_cnt <= (low_side_gate_o || high_side_gate_o) ? 16'h0000 : dead_cnt + 16'h0001;
            seen_on  <= seen_on | low_side_gate_o | high_side_gate_o;
            // which gate was on last; a low side after a hold is not a gate change
            if (high_side_gate_o)
                last_hs <= 1'b1;
            else if (low_side_gate_o)
                last_hs <= 1'b0;
        end
    end
    gate_excl_a: assert property (!(low_side_gate_o && high_side_gate_o))
        else $error("both gates on together");
    dead_min_a: assert property (($rose(high_side_gate_o) || ($rose(low_side_gate_o) && last_hs)) && seen_on
        |-> dead_cnt >= 16'd25)
        else $error("dead time shorter than minimum non-overlap");
    on_min_a: assert property ($fell(low_side_gate_o) || $fell(high_side_gate_o) |-> on_cnt >= 16'd100)
        else $error("gate on shorter than minimum on-time");
    on_max_a: assert property (on_cnt <= TON_MAX_CYC + 4)
        else $error("gate on longer than maximum on-time");
    dead_max_a: assert property ((mode_o == 3'h1 && !cur_pos_i && !cur_neg_i)[*6] ##0 dead_cnt > 16'd250
        |-> ##[0:2] (low_side_gate_o || high_side_gate_o))
        else $error("dead time not ended at maximum non-overlap");
    ls_exit_a: assert property ((low_side_gate_o && on_cnt > 16'd104 && (cap_below_low_i || overcurrent_i || near_cap_i))[*3]
        |-> ##[0:3] !low_side_gate_o)
        else $error("low side not ended by its exit condition");
    hs_exit_a: assert property ((high_side_gate_o && on_cnt > 16'd104 && (cap_above_high_i || overcurrent_i || near_cap_i))[*3]
        |-> ##[0:3] !high_side_gate_o)
        else $error("high side not ended by its exit condition");
    gap_floor_a: assert property (cap_gap_o >= 10'h040)
        else $error("threshold gap below minimum");
endmodule

bind rhbm_ctrl rhbm_ctrl_chk #(.GAP_W(GAP_W), .TON_MAX_CYC(TON_MAX_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cap_above_high_i(cap_above_high_i), .cap_below_low_i(cap_below_low_i),
    .hb_peak_i(hb_peak_i), .cur_pos_i(cur_pos_i), .cur_neg_i(cur_neg_i), .overcurrent_i(overcurrent_i),
    .near_cap_i(near_cap_i), .opto_ua_i(opto_ua_i), .lp_transition_i(lp_transition_i), .burst_sel_i(burst_sel_i),
    .low_side_gate_o(low_side_gate_o), .high_side_gate_o(high_side_gate_o), .cap_gap_o(cap_gap_o), .mode_o(mode_o));

// >>> rhbm_bridge_model.sv
// behavioural half-bridge with its sense comparators
// assumes gate commands arrive on the same clock as the controller
`timescale 1ns/1ps
module rhbm_bridge_model (
    input  wire logic        clk_sys_i,        // system clock
    input  wire logic        low_gate_i,       // low gate command
    input  wire logic        high_gate_i,      // high gate command
    input  wire logic [15:0] on_len_i,         // cycles until threshold crossed
    input  wire logic        peak_en_i,        // node peak shows in dead time
    output logic             cap_above_high_o, // cap above high threshold
    output logic             cap_below_low_o,  // cap below low threshold
    output logic             hb_peak_o,        // node peak seen
    output logic             cur_pos_o,        // current above zero
    output logic             cur_neg_o         // current below zero
);
    logic [15:0] cnt = 16'h0000;
    logic [1:0]  last = 2'h0;
    // time spent in the present gate state
    always_ff @(posedge clk_sys_i) begin
        last <= {high_gate_i, low_gate_i};
        cnt  <= ({high_gate_i, low_gate_i} == last) ? cnt + 16'h0001 : 16'h0000;
    end
    // cap swings past a threshold after on_len; current zero while both off
    assign cap_below_low_o  = low_gate_i && cnt >= on_len_i;
    assign cap_above_high_o = high_gate_i && cnt >= on_len_i;
    assign hb_peak_o        = peak_en_i && !low_gate_i && !high_gate_i && cnt >= 16'd30;
    assign cur_pos_o        = high_gate_i;
    assign cur_neg_o        = low_gate_i;
endmodule

// >>> testbench.sv
// self-checking bench for the half-bridge mode controller
// shortened on-time, low-power period and burst clock; bridge model on the far side
`timescale 1ns/1ps
module testbench;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        cap_hi, cap_lo, peak, c_pos, c_neg, low_g, high_g;
    logic        overcurrent = 1'b0;
    logic        near_cap    = 1'b0;
    logic        peak_en     = 1'b1;
    logic [9:0]  opto_ua     = 10'h00A;
    logic [1:0]  burst_sel   = 2'h0;
    logic [15:0] on_len      = 16'h0080;
    logic [9:0]  gap;
    logic [2:0]  mode;
    int          n_errors = 0;
    int          checks   = 0;
    int          cyc      = 0;
    int          t, k, busy;
    rhbm_ctrl #(.TON_MAX_CYC(200), .LP_MAX_CYC(900), .CLK_HZ(1000000)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cap_above_high_i(cap_hi), .cap_below_low_i(cap_lo),
        .hb_peak_i(peak), .cur_pos_i(c_pos), .cur_neg_i(c_neg), .overcurrent_i(overcurrent), .near_cap_i(near_cap),
        .opto_ua_i(opto_ua), .lp_transition_i(10'h200), .burst_sel_i(burst_sel), .low_side_gate_o(low_g),
        .high_side_gate_o(high_g), .cap_gap_o(gap), .mode_o(mode));
    rhbm_bridge_model bridge (.clk_sys_i(clk_sys_i), .low_gate_i(low_g), .high_gate_i(high_g), .on_len_i(on_len),
        .peak_en_i(peak_en), .cap_above_high_o(cap_hi), .cap_below_low_o(cap_lo), .hb_peak_o(peak),
        .cur_pos_o(c_pos), .cur_neg_o(c_neg));
    always #2 clk_sys_i = ~clk_sys_i;
    // run ceiling
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 98000) begin
            n_errors++;
            results();
        end
    end
    task results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // wait for 0 low gate, 1 high gate, 2 burst mode, 3 low-power mode
    task wait_sig(input int which, input logic val, input int lim, output int n);
        n = 0;
        while (n < lim && (which == 0 ? low_g : which == 1 ? high_g : mode[4 - which]) !== val) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys_i);
        check("mode_rst", mode, 3'h1);
        check("gap_rst", gap, 10'h3FF);
        rst_b_i = 1'b1;
        wait_sig(0, 1, 8, t);
        check("ls_after_rst", {low_g, high_g}, 2'h2);
        wait_sig(0, 0, 400, t);
        check("ls_on_time", t >= 98 && t <= 140, 1);
        check("hp_gap", gap, 10'h3EB);
        wait_sig(1, 1, 300, t);
        check("dead_peak", t >= 24 && t <= 45, 1);
        wait_sig(1, 0, 400, t);
        check("hs_on_time", t >= 98 && t <= 140, 1);
        peak_en = 1'b0;
        wait_sig(0, 1, 400, t);
        check("dead_no_peak", t >= 245 && t <= 262, 1);
        peak_en = 1'b1;
        on_len = 16'hFFFF;
        wait_sig(0, 0, 400, t);
        check("ls_max_on", t >= 195 && t <= 210, 1);
        for (k = 1; k >= 0; k--) begin
            wait_sig(k, 1, 800, t);
            overcurrent = (k == 0);
            near_cap = (k == 1);
            wait_sig(k, 0, 400, t);
            overcurrent = 1'b0;
            near_cap = 1'b0;
            check("exit_cause", t >= 98 && t <= 112, 1);
        end
        on_len = 16'h0070;
        opto_ua = 10'h190;
        wait_sig(3, 1, 4000, t);
        check("enter_lp", mode, 3'h2);
        check("lp_gap_raised", gap >= 10'h0C0, 1);
        wait_sig(1, 1, 3000, t);
        wait_sig(1, 0, 400, t);
        wait_sig(0, 1, 100, t);
        wait_sig(0, 0, 400, t);
        wait_sig(1, 1, 60, t);
        check("lp_hold", t, 60);
        wait_sig(2, 1, 40000, t);
        check("enter_burst", mode, 3'h4);
        for (k = 0; k < 4; k++) begin
            burst_sel = k[1:0];
            opto_ua = 10'h190;
            busy = 0;
            while (busy < 600 && cyc < 90000) begin
                @(negedge clk_sys_i);
                busy = (low_g || high_g) ? 0 : busy + 1;
            end
            busy = 0;
            repeat (1000) begin
                @(negedge clk_sys_i);
                busy += (low_g || high_g);
            end
            check("burst_idle", busy == 0, 1);
            opto_ua = 10'h05A;
            wait_sig(0, 1, 400, t);
            check("burst_on", t < 400, 1);
        end
        results();
    end
endmodule
